/* hdl/vic_pkg.sv */
// Package for the interpolated oscillator control block: offsets, fields,
// reset values and bus types.
// Assumes a 32-bit AHB-Lite register bus and a single clock domain.
package vic_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] INPUT_OFFSET   = 8'h04;
	localparam logic [7:0] DIVIDER_OFFSET = 8'h08;
	localparam logic [7:0] STATUS_OFFSET  = 8'h0c;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          RUN_BIT        = 0;
	localparam int          RES_LSB        = 1;
	localparam int          FIELD_WIDTH    = 16;
	localparam logic [15:0] INPUT_RESET    = 16'h0000;
	localparam logic [15:0] DIVIDER_RESET  = 16'h0001;
	localparam logic [15:0] DIVIDER_ILLEGAL = 16'h0000;
	localparam logic [2:0]  RES_RESET      = 3'h0;
	localparam logic [4:0]  FULL_BITS      = 5'h10;

	// ------------------------------------------------------------
	// Bus transfer codes
	// ------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic [31:0] hwdata;
	} vic_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} vic_ahb_rsp_t;

	typedef struct packed {
		logic        run;
		logic [2:0]  resolution;
		logic [15:0] input_value;
		logic [15:0] divider;
	} vic_config_t;

endpackage

/* hdl/vic_modulator.sv */
// Interpolation core: divided-rate tick and first-order sigma-delta
// modulator producing the one-bit oscillator control.
// Assumes configuration from the register bank on the same clock.
`timescale 1ns/1ps
`default_nettype none

module vic_modulator (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 reset,
	// Configuration
	input  wire vic_pkg::vic_config_t cfg,
	// Outputs
	output var  logic                 ctl_out,
	output var  logic                 period_start
);

	logic [15:0] div_count_reg;
	logic [15:0] div_count_next;
	logic [3:0]  step_reg;
	logic [3:0]  step_next;
	logic [15:0] acc_reg;
	logic [15:0] acc_next;
	logic [15:0] held_reg;
	logic [15:0] held_next;
	logic        ctl_reg;
	logic        ctl_next;
	logic        start_reg;
	logic        start_next;
	logic [15:0] div_eff;
	logic [15:0] res_mask;
	logic [15:0] in_trunc;
	logic [3:0]  last_step;
	logic [16:0] sum;
	logic        tick;

	// ------------------------------------------------------------
	// Per-bit mask keeps only the top bits of the input
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_mask
			assign res_mask[gi] = (gi >= int'(cfg.resolution)); // RULE_02
		end
	endgenerate

	always_comb begin
		div_eff   = (cfg.divider == vic_pkg::DIVIDER_ILLEGAL) ?
			vic_pkg::DIVIDER_RESET : cfg.divider; // RULE_07
		in_trunc  = cfg.input_value & res_mask; // RULE_02
		last_step = 4'hf - {1'b0, cfg.resolution}; // RULE_10
		tick      = (div_count_reg >= div_eff - 16'h0001); // RULE_05
		sum       = {1'b0, acc_reg} + {1'b0, held_reg & res_mask}; // RULE_02
		div_count_next = tick ? 16'h0000 : div_count_reg + 16'h0001;
		step_next  = step_reg;
		acc_next   = acc_reg;
		held_next  = held_reg;
		ctl_next   = ctl_reg;
		start_next = 1'b0;
		if (tick) begin
			acc_next = sum[15:0];
			ctl_next = sum[16];
			if (step_reg >= last_step) begin
				step_next  = 4'h0;
				held_next  = in_trunc; // RULE_12
				start_next = 1'b1;
			end else begin
				step_next = step_reg + 4'h1;
			end
		end
		if (!cfg.run) begin // RULE_11
			div_count_next = 16'h0000;
			step_next  = 4'h0;
			acc_next   = 16'h0000;
			held_next  = in_trunc;
			ctl_next   = 1'b0;
			start_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			div_count_reg <= 16'h0000;
			step_reg      <= 4'h0;
			acc_reg       <= 16'h0000;
			held_reg      <= vic_pkg::INPUT_RESET;
			ctl_reg       <= 1'b0;
			start_reg     <= 1'b0;
		end else begin
			div_count_reg <= div_count_next;
			step_reg      <= step_next;
			acc_reg       <= acc_next;
			held_reg      <= held_next;
			ctl_reg       <= ctl_next;
			start_reg     <= start_next;
		end
	end

	assign ctl_out      = ctl_reg;
	assign period_start = start_reg;

endmodule

`default_nettype wire

/* hdl/vic_top.sv */
// Register bank and AHB-Lite slave of the interpolated oscillator control.
// Assumes a single AHB-Lite master on the same 10 MHz clock.
//
// Functional notes
// RULE_01: Input register writes take effect only while run is set.
// RULE_02: Reduced resolutions use the top bits of the input value.
// RULE_03: Bits 31-16 of input and divider read zero, writes ignored.
// RULE_04: Input register is 16-bit read/write, reset zero.
// RULE_05: Interpolation rate is the module clock divided by the divider.
// RULE_06: Software sets divider to rounded module clock over wanted rate.
// RULE_07: Divider resets to 1; a written 0 acts as 1.
// RULE_08: Divider writes only while run is clear; otherwise ignored.
// RULE_09: Divider field is bits 15-0, read/write, up to ffff.
// RULE_10: Resolution code 0 is 16 bits, each step one bit less, 7 is 9.
// RULE_11: Run clear holds interpolation in reset and drives output low.
// RULE_12: New input values apply at the next interpolation period boundary.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module vic_top (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  reset,
	// AHB-Lite slave
	input  wire vic_pkg::vic_ahb_req_t ahb_req,
	output var  vic_pkg::vic_ahb_rsp_t ahb_rsp,
	// Oscillator control
	output var  logic                  oscillator_control_out
);

	logic        run_reg;
	logic        run_next;
	logic [2:0]  res_reg;
	logic [2:0]  res_next;
	logic [15:0] input_value_field_reg;
	logic [15:0] input_value_field_next;
	logic [15:0] divider_field_reg;
	logic [15:0] divider_field_next;
	logic        wr_pend_reg;
	logic        wr_pend_next;
	logic [7:0]  addr_reg;
	logic [7:0]  addr_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        out_reg;
	logic        out_next;
	logic        period_seen_reg;
	logic        period_seen_next;
	logic        addr_phase;
	logic        core_out;
	logic        core_start;
	logic [31:0] wdata;
	vic_pkg::vic_config_t cfg;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	assign addr_phase = ahb_req.hsel && ahb_req.hready &&
		(ahb_req.htrans == vic_pkg::HTRANS_NONSEQ ||
		 ahb_req.htrans == vic_pkg::HTRANS_SEQ);
	assign wdata = ahb_req.hwdata;

	always_comb begin
		wr_pend_next = addr_phase && ahb_req.hwrite;
		addr_next    = addr_phase ? ahb_req.haddr[7:0] : addr_reg;
		run_next     = run_reg;
		res_next     = res_reg;
		input_value_field_next = input_value_field_reg;
		divider_field_next     = divider_field_reg;
		if (wr_pend_reg) begin
			case (addr_reg)
			vic_pkg::CONTROL_OFFSET: begin
				run_next = wdata[vic_pkg::RUN_BIT];
				if (!run_reg) begin
					res_next = wdata[vic_pkg::RES_LSB +: 3]; // RULE_10
				end
			end
			vic_pkg::INPUT_OFFSET: begin
				if (run_reg) begin
					input_value_field_next = wdata[15:0]; // RULE_01 RULE_04
				end
			end
			vic_pkg::DIVIDER_OFFSET: begin
				if (!run_reg) begin
					divider_field_next = wdata[15:0]; // RULE_08 RULE_09
				end
			end
			default: begin
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read data, registered in the address phase
	// ------------------------------------------------------------
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (addr_phase && !ahb_req.hwrite) begin
			case (ahb_req.haddr[7:0])
			vic_pkg::CONTROL_OFFSET:
				rdata_next = {28'h0000000, res_reg, run_reg};
			vic_pkg::INPUT_OFFSET:
				rdata_next = {16'h0000, input_value_field_reg}; // RULE_03
			vic_pkg::DIVIDER_OFFSET:
				rdata_next = {16'h0000, divider_field_reg}; // RULE_03
			vic_pkg::STATUS_OFFSET:
				rdata_next = {30'h00000000, period_seen_reg, out_reg};
			default:
				rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Status: period boundary seen, cleared when run is dropped
	// ------------------------------------------------------------
	always_comb begin
		out_next = core_out;
		period_seen_next = period_seen_reg;
		if (core_start) begin
			period_seen_next = 1'b1;
		end else if (!run_reg) begin
			period_seen_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			run_reg               <= 1'b0;
			res_reg               <= vic_pkg::RES_RESET;
			input_value_field_reg <= vic_pkg::INPUT_RESET; // RULE_04
			divider_field_reg     <= vic_pkg::DIVIDER_RESET; // RULE_07
			wr_pend_reg           <= 1'b0;
			addr_reg              <= 8'h00;
			rdata_reg             <= 32'h0000_0000;
			out_reg               <= 1'b0;
			period_seen_reg       <= 1'b0;
		end else begin
			run_reg               <= run_next;
			res_reg               <= res_next;
			input_value_field_reg <= input_value_field_next;
			divider_field_reg     <= divider_field_next;
			wr_pend_reg           <= wr_pend_next;
			addr_reg              <= addr_next;
			rdata_reg             <= rdata_next;
			out_reg               <= out_next;
			period_seen_reg       <= period_seen_next;
		end
	end

	// ------------------------------------------------------------
	// Interpolation core
	// ------------------------------------------------------------
	assign cfg.run         = run_reg;
	assign cfg.resolution  = res_reg;
	assign cfg.input_value = input_value_field_reg;
	assign cfg.divider     = divider_field_reg;

	vic_modulator u_mod (
		.clock        (clock),
		.reset        (reset),
		.cfg          (cfg),
		.ctl_out      (core_out),
		.period_start (core_start)
	);

	assign ahb_rsp.hrdata    = rdata_reg;
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp     = 1'b0;
	assign oscillator_control_out = out_reg;

endmodule

`default_nettype wire

/* tb/vic_top_properties.sv */
// Checker for the register bank and oscillator control output.
// Assumes one AHB-Lite master and the bind in the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module vic_top_properties (
	// Clock and reset
	input wire logic                  clock,
	input wire logic                  reset,
	// Bus and output
	input wire vic_pkg::vic_ahb_req_t ahb_req,
	input wire vic_pkg::vic_ahb_rsp_t ahb_rsp,
	input wire logic                  oscillator_control_out
);
	logic        rd_reg, wr_reg, run_reg;
	logic [7:0]  a_reg;
	logic [2:0]  res_reg;
	logic [15:0] in_reg, div_reg;
	logic [31:0] exp_reg;
	wire         take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
	// Shadow registers, read data captured at the address edge
	always_ff @(posedge clock) begin
		if (reset) begin
			{rd_reg, wr_reg, run_reg, res_reg, in_reg} <= '0;
			{a_reg, exp_reg} <= '0;
			div_reg <= 16'h0001;
		end else begin
			rd_reg <= take && !ahb_req.hwrite;
			wr_reg <= take && ahb_req.hwrite;
			a_reg <= ahb_req.haddr[7:0];
			case (ahb_req.haddr[7:0])
				8'h00: exp_reg <= {28'h0, res_reg, run_reg};
				8'h04: exp_reg <= {16'h0, in_reg};
				8'h08: exp_reg <= {16'h0, div_reg};
				default: exp_reg <= '0;
			endcase
			if (wr_reg && a_reg == 8'h00) begin
				run_reg <= ahb_req.hwdata[0];
				if (!run_reg) res_reg <= ahb_req.hwdata[3:1];
			end
			if (wr_reg && a_reg == 8'h04 && run_reg) in_reg <= ahb_req.hwdata[15:0];
			if (wr_reg && a_reg == 8'h08 && !run_reg) div_reg <= ahb_req.hwdata[15:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	hready_high_a: assert property (ahb_rsp.hreadyout)
		else $error("wait state inserted");
	okay_resp_a: assert property (!ahb_rsp.hresp)
		else $error("error response");
	idle_rdata_a: assert property (!rd_reg |-> ahb_rsp.hrdata == '0)
		else $error("read data outside a read");
	read_data_a: assert property (
		rd_reg && a_reg != 8'h0c |-> ahb_rsp.hrdata == exp_reg)
		else $error("register read mismatch");
	upper_zero_a: assert property (rd_reg |-> ahb_rsp.hrdata[31:16] == '0)
		else $error("upper half not zero");
	stopped_low_a: assert property (!run_reg [*3] |-> !oscillator_control_out)
		else $error("output high while stopped");
	reset_low_a: assert property (disable iff (1'b0) reset [*2] |-> !oscillator_control_out)
		else $error("output high in reset");
	rise_run_a: assert property (
		$rose(oscillator_control_out) |-> $past(run_reg, 2))
		else $error("output rose without run");
	cover property (wr_reg && a_reg == 8'h08);
	cover property (rd_reg && a_reg == 8'h04);
	cover property ($rose(oscillator_control_out));
endmodule
`default_nettype wire

/* tb/vic_vcxo_model.sv */
// Oscillator and filter model: integrates the one-bit control.
// Assumes the control output is sampled on the block clock.
`timescale 1ns/1ps
`default_nettype none
module vic_vcxo_model (
	// Clock and counter clear
	input wire logic clock,
	input wire logic clear,
	// Control in, integrated ones count and rising-edge count out
	input wire logic ctl,
	output var int   ones,
	output var int   rises
);
	logic prev = 1'b0;
	// Ones give the duty, rises give the rate at which the bit goes high
	always @(posedge clock) begin
		ones  <= clear ? 0 : ones + int'(ctl);
		rises <= clear ? 0 : rises + int'(ctl && !prev);
		prev  <= ctl;
	end
endmodule
`default_nettype wire

/* tb/vcxo_interp_input_divider_test.sv */
// Testbench: register access over AHB-Lite and control output density.
// Assumes a zero wait state slave and the oscillator model.
`timescale 1ns/1ps
`default_nettype none
module vcxo_interp_input_divider_test;
	logic                  clock = 0, reset = 1, clr = 1, osc;
	int                    ones, rises, fail_count = 0, samples_checked = 0;
	logic [31:0]           r, v, m_in = 0, m_div = 1, m_run = 0;
	vic_pkg::vic_ahb_req_t req = '0, bus;
	vic_pkg::vic_ahb_rsp_t rsp;
	always #50 clock = ~clock;
	always_comb begin
		bus = req;
		bus.hready = rsp.hreadyout;
	end
	vic_top dut (.clock(clock), .reset(reset), .ahb_req(bus), .ahb_rsp(rsp),
		.oscillator_control_out(osc));
	vic_vcxo_model vcxo (.clock(clock), .clear(clr), .ctl(osc), .ones(ones),
		.rises(rises));
	task report_and_stop;
		if (fail_count == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t read %h expected %h", $time, g, e);
		end
	endtask
	task chk_rate(input int lo, input int hi, input int rlo, input int rhi);
		samples_checked++;
		if (ones < lo || ones > hi || rises < rlo || rises > rhi) begin
			fail_count++;
			$display("[FAIL] %0t pulses %0d rises %0d", $time, ones, rises);
		end
		@(posedge clock);
	endtask
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (rsp.hreadyout !== 1'b1 && n < 20);
		if (rsp.hreadyout !== 1'b1) begin
			fail_count++;
			report_and_stop;
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		req.hsel <= 1'b1;
		req.htrans <= vic_pkg::HTRANS_NONSEQ;
		req.haddr <= {24'h0, a};
		req.hwrite <= w;
		req.hsize <= 3'h2;
		wait_ready;
		req.htrans <= 2'h0;
		req.hsel <= 1'b0;
		req.hwdata <= d;
		wait_ready;
		r = rsp.hrdata;
		@(posedge clock);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		if (a == 8'h00) m_run = {31'h0, d[0]};
		if (a == 8'h04 && m_run[0]) m_in = {16'h0, d[15:0]};
		if (a == 8'h08 && !m_run[0]) m_div = {16'h0, d[15:0]};
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(r, e);
	endtask
	task measure(input int n);
		repeat (80) @(posedge clock);
		clr <= 1'b0;
		repeat (n) @(posedge clock);
		clr <= 1'b1;
		// Read the counts once the last sample has landed
		@(negedge clock);
	endtask
	initial begin
		v = $urandom(32'h0006);
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rd(8'h04, m_in);
		rd(8'h08, m_div);
		wr(8'h04, 32'habcd1234);
		rd(8'h04, m_in);
		wr(8'h08, 32'hffff0000);
		rd(8'h08, m_div);
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h8000);
		rd(8'h04, m_in);
		measure(64);
		chk_rate(31, 33, 31, 33);
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			wr(8'h04, v);
			rd(8'h04, m_in);
			wr(8'h08, v);
			rd(8'h08, m_div);
		end
		wr(8'h04, 32'h8000);
		wr(8'h00, 32'h0);
		wr(8'h08, 32'h2);
		rd(8'h08, m_div);
		wr(8'h00, 32'h1);
		measure(128);
		chk_rate(63, 65, 31, 33);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'hf);
		rd(8'h00, 32'hf);
		wr(8'h04, 32'h007f);
		measure(1000);
		chk_rate(0, 0, 0, 0);
		report_and_stop;
	end
endmodule
bind vic_top vic_top_properties chk_i (.clock(clock), .reset(reset),
	.ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
	.oscillator_control_out(oscillator_control_out));
`default_nettype wire
